/* File: rtl/dtcr_pkg.sv */
// Package holding constants and carrier types of the dual timer capture/reload block.
package dtcr_pkg;
    localparam int TIMER_W = 16;
    localparam int PRESC_W = 3;
    localparam int BASE_DIV = 2;
    localparam logic [15:0] TIMER_RESET = 16'h0000;
    localparam logic [15:0] TIMER_MAX = 16'hFFFF;
    localparam logic [15:0] TIMER_MIN = 16'h0000;
    localparam logic [2:0] PRESC_RESET = 3'h0;

    // Count clock source of a timer.
    typedef enum logic [1:0] {
        DTCR_SRC_PRESC = 2'h0,
        DTCR_SRC_PIN = 2'h1,
        DTCR_SRC_TOGGLE = 2'h2,
        DTCR_SRC_OFF = 2'h3
    } dtcr_src_e;

    // Edge selection for capture and external count inputs.
    typedef enum logic [1:0] {
        DTCR_EDGE_NONE = 2'h0,
        DTCR_EDGE_RISE = 2'h1,
        DTCR_EDGE_FALL = 2'h2,
        DTCR_EDGE_BOTH = 2'h3
    } dtcr_edge_e;

    typedef struct packed {
        logic run;
        dtcr_src_e src;
        dtcr_edge_e pinEdge;
        logic [2:0] presc;
        logic downSw;
        logic dirPinEn;
    } dtcr_tcfg_s;

    typedef struct packed {
        dtcr_edge_e capEdge;
        dtcr_edge_e quadAEdge;
        dtcr_edge_e quadBEdge;
        logic clearOnCap;
        logic reloadEn;
        logic toggleOutEn;
    } dtcr_ccfg_s;
endpackage

/* File: rtl/dtcr_timer_group.sv */
// Timer group with auxiliary and core timers plus capture/reload register.
//
// Behaviour
// - Finest count step is two system clock cycles.
// - Each timer counts prescaled system clock or an external input signal.
// - Direction from software bit, inverted by direction pin level when enabled.
// - Core toggle latch inverts on every core overflow or underflow.
// - Toggle latch may clock auxiliary timer and drives toggle output pin, whose enable is high only while toggleOutEn is clear.
// - Core overflow/underflow pulses are offered to capture/compare unit timers.
// - When enabled, core overflow/underflow reloads core from capture/reload register.
// - Selected capture pin edge copies auxiliary count into capture/reload register.
// - With clear option, auxiliary timer goes to zero right after capture.
// - Neighbor timer quadrature input edges may also trigger the capture.
// - Both timers are sixteen bits and wrap; only the core timer gives overflow/underflow events.
`timescale 1ns/10ps
`default_nettype none
module dtcr_timer_group #(
    parameter int TIMER_W = dtcr_pkg::TIMER_W
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire dtcr_pkg::dtcr_tcfg_s auxCfg,
    input wire dtcr_pkg::dtcr_tcfg_s coreCfg,
    input wire dtcr_pkg::dtcr_ccfg_s capCfg,
    input wire logic auxCountPin,
    input wire logic coreCountPin,
    input wire logic auxDirPin,
    input wire logic coreDirPin,
    input wire logic capturePin,
    input wire logic quadInputA,
    input wire logic quadInputB,
    output logic [TIMER_W-1:0] auxTimer,
    output logic [TIMER_W-1:0] coreTimer,
    output logic [TIMER_W-1:0] captureReloadReg,
    output logic coreToggleLatch,
    output logic toggleLatchOutPin,
    output logic toggleLatchOutEn,
    output logic capcompClockPulse,
    output logic captureEvent
);
    // Pin index: 0 auxCount, 1 coreCount, 2 auxDir, 3 coreDir, 4 capture, 5 quadA, 6 quadB.
    localparam int NPIN = 7;
    logic [NPIN-1:0] pinRaw;
    logic [NPIN-1:0] syncA_r;
    logic [NPIN-1:0] syncB_r;
    logic [NPIN-1:0] prev_r;
    logic [NPIN-1:0] rise;
    logic [NPIN-1:0] fall;

    assign pinRaw = {quadInputB, quadInputA, capturePin, coreDirPin, auxDirPin,
                     coreCountPin, auxCountPin};

    // Pins are asynchronous; the first stage is read only by the second.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            syncA_r <= '0;
            syncB_r <= '0;
            prev_r <= '0;
        end else begin
            syncA_r <= pinRaw;
            syncB_r <= syncA_r;
            prev_r <= syncB_r;
        end
    end

    assign rise = syncB_r & ~prev_r;
    assign fall = ~syncB_r & prev_r;

    function automatic logic edgeHit(input dtcr_pkg::dtcr_edge_e sel, input logic r,
                                     input logic f);
        edgeHit = ((sel == dtcr_pkg::DTCR_EDGE_RISE) && r) ||
                  ((sel == dtcr_pkg::DTCR_EDGE_FALL) && f) ||
                  ((sel == dtcr_pkg::DTCR_EDGE_BOTH) && (r || f));
    endfunction

    // Base divider gives a tick every two system cycles, the finest step.
    logic baseDiv_r;
    logic baseDiv_nxt;
    logic baseTick;
    logic [7:0] presc_r;
    logic [7:0] presc_nxt;
    always_comb begin
        baseDiv_nxt = ~baseDiv_r;
        presc_nxt = baseDiv_r ? presc_r + 8'h01 : presc_r;
    end
    assign baseTick = baseDiv_r;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            baseDiv_r <= 1'b0;
            presc_r <= 8'h00;
        end else begin
            baseDiv_r <= baseDiv_nxt;
            presc_r <= presc_nxt;
        end
    end

    // Prescaler tap: a tick when all bits below the selected stage are ones.
    function automatic logic prescTick(input logic [2:0] sel, input logic [7:0] cnt,
                                       input logic tick);
        logic [7:0] mask;
        mask = 8'h00;
        mask = (8'h01 << sel) - 8'h01;
        prescTick = tick && ((cnt & mask) == mask);
    endfunction

    logic auxStep;
    logic coreStep;
    logic auxDown;
    logic coreDown;
    logic coreWrap;
    logic capTrig;
    logic auxClr;
    logic toggleEdge;

    always_comb begin
        unique case (coreCfg.src)
            dtcr_pkg::DTCR_SRC_PRESC: coreStep = prescTick(coreCfg.presc, presc_r, baseTick);
            dtcr_pkg::DTCR_SRC_PIN: coreStep = edgeHit(coreCfg.pinEdge, rise[1], fall[1]);
            default: coreStep = 1'b0;
        endcase
        unique case (auxCfg.src)
            dtcr_pkg::DTCR_SRC_PRESC: auxStep = prescTick(auxCfg.presc, presc_r, baseTick);
            dtcr_pkg::DTCR_SRC_PIN: auxStep = edgeHit(auxCfg.pinEdge, rise[0], fall[0]);
            dtcr_pkg::DTCR_SRC_TOGGLE: auxStep = toggleEdge;
            default: auxStep = 1'b0;
        endcase
        auxStep = auxStep && auxCfg.run;
        coreStep = coreStep && coreCfg.run;
        auxDown = auxCfg.dirPinEn ? (auxCfg.downSw ^ syncB_r[2]) : auxCfg.downSw;
        coreDown = coreCfg.dirPinEn ? (coreCfg.downSw ^ syncB_r[3]) : coreCfg.downSw;
    end

    // Core timer and toggle latch.
    logic [TIMER_W-1:0] core_r;
    logic [TIMER_W-1:0] core_nxt;
    // The reload reads the capture register, so it is declared ahead of the core timer logic.
    logic [TIMER_W-1:0] capture_reload_reg_r;
    logic [TIMER_W-1:0] capture_reload_reg_nxt;
    logic tgl_r;
    logic tgl_nxt;
    logic wrap_r;
    logic wrap_nxt;
    always_comb begin
        coreWrap = coreStep && (coreDown ? (core_r == TIMER_W'(dtcr_pkg::TIMER_MIN))
                                         : (core_r == TIMER_W'(dtcr_pkg::TIMER_MAX)));
        core_nxt = core_r;
        if (coreStep) begin
            core_nxt = coreDown ? core_r - TIMER_W'(1) : core_r + TIMER_W'(1);
        end
        if (coreWrap && capCfg.reloadEn) begin
            core_nxt = capture_reload_reg_r;
        end
        tgl_nxt = coreWrap ? ~tgl_r : tgl_r;
        wrap_nxt = coreWrap;
    end
    // A latch change is a step for the auxiliary timer in the cycle after it.
    assign toggleEdge = wrap_r;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            core_r <= TIMER_W'(dtcr_pkg::TIMER_RESET);
            tgl_r <= 1'b0;
            wrap_r <= 1'b0;
        end else begin
            core_r <= core_nxt;
            tgl_r <= tgl_nxt;
            wrap_r <= wrap_nxt;
        end
    end

    // Auxiliary timer and capture/reload register.
    logic [TIMER_W-1:0] aux_r;
    logic [TIMER_W-1:0] aux_nxt;
    logic capEv_r;
    logic capEv_nxt;
    always_comb begin
        capTrig = edgeHit(capCfg.capEdge, rise[4], fall[4]) ||
                  edgeHit(capCfg.quadAEdge, rise[5], fall[5]) ||
                  edgeHit(capCfg.quadBEdge, rise[6], fall[6]);
        auxClr = capTrig && capCfg.clearOnCap;
        aux_nxt = aux_r;
        if (auxStep) begin
            aux_nxt = auxDown ? aux_r - TIMER_W'(1) : aux_r + TIMER_W'(1);
        end
        // Clearing wins over a count step so the next interval starts at zero.
        if (auxClr) begin
            aux_nxt = '0;
        end
        // A reload only reads the register, so it is written by capture alone.
        capture_reload_reg_nxt = capTrig ? aux_r : capture_reload_reg_r;
        capEv_nxt = capTrig;
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            aux_r <= TIMER_W'(dtcr_pkg::TIMER_RESET);
            capture_reload_reg_r <= TIMER_W'(dtcr_pkg::TIMER_RESET);
            capEv_r <= 1'b0;
        end else begin
            aux_r <= aux_nxt;
            capture_reload_reg_r <= capture_reload_reg_nxt;
            capEv_r <= capEv_nxt;
        end
    end

    assign auxTimer = aux_r;
    assign coreTimer = core_r;
    assign captureReloadReg = capture_reload_reg_r;
    assign coreToggleLatch = tgl_r;
    assign toggleLatchOutPin = tgl_r;
    assign toggleLatchOutEn = ~capCfg.toggleOutEn;
    assign capcompClockPulse = wrap_r;
    assign captureEvent = capEv_r;

    // Assertions.
    property p_base_div;
        @(posedge clk_sys) disable iff (rst) baseTick |=> !baseTick;
    endproperty
    a_base_div: assert property (p_base_div) else $error("base tick faster than two cycles");

    property p_toggle;
        @(posedge clk_sys) disable iff (rst) coreWrap |=> (tgl_r != $past(tgl_r));
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle latch did not invert");

    property p_toggle_hold;
        @(posedge clk_sys) disable iff (rst) !coreWrap |=> (tgl_r == $past(tgl_r));
    endproperty
    a_toggle_hold: assert property (p_toggle_hold) else $error("toggle latch changed");

    property p_capcomp;
        @(posedge clk_sys) disable iff (rst) coreWrap |=> capcompClockPulse;
    endproperty
    a_capcomp: assert property (p_capcomp) else $error("capcomp pulse missing");

    property p_reload;
        @(posedge clk_sys) disable iff (rst)
            (coreWrap && capCfg.reloadEn) |=> (core_r == $past(capture_reload_reg_r));
    endproperty
    a_reload: assert property (p_reload) else $error("core not reloaded");

    property p_capture;
        @(posedge clk_sys) disable iff (rst) capTrig |=> (capture_reload_reg_r == $past(aux_r));
    endproperty
    a_capture: assert property (p_capture) else $error("capture value wrong");

    property p_clear;
        @(posedge clk_sys) disable iff (rst) auxClr |=> (aux_r == '0);
    endproperty
    a_clear: assert property (p_clear) else $error("aux not cleared");

    property p_keep;
        @(posedge clk_sys) disable iff (rst) !capTrig |=> $stable(capture_reload_reg_r);
    endproperty
    a_keep: assert property (p_keep) else $error("capture reg changed");

    property p_wrap_up;
        @(posedge clk_sys) disable iff (rst)
            (coreStep && !coreDown && core_r == TIMER_W'(dtcr_pkg::TIMER_MAX) && !capCfg.reloadEn)
            |=> core_r == '0;
    endproperty
    a_wrap_up: assert property (p_wrap_up) else $error("core wrap wrong");

    property p_wrap_down;
        @(posedge clk_sys) disable iff (rst)
            (coreStep && coreDown && core_r == TIMER_W'(dtcr_pkg::TIMER_MIN) && !capCfg.reloadEn)
            |=> core_r == TIMER_W'(dtcr_pkg::TIMER_MAX);
    endproperty
    a_wrap_down: assert property (p_wrap_down) else $error("core underflow wrong");

    // A timer without a step must hold still; a prescaler stuck on would break this.
    property p_core_hold;
        @(posedge clk_sys) disable iff (rst) !coreStep |=> $stable(core_r);
    endproperty
    a_core_hold: assert property (p_core_hold) else $error("core changed without step");

    property p_aux_hold;
        @(posedge clk_sys) disable iff (rst) (!auxStep && !auxClr) |=> $stable(aux_r);
    endproperty
    a_aux_hold: assert property (p_aux_hold) else $error("aux changed without step");

    property p_core_dir;
        @(posedge clk_sys) disable iff (rst) (coreStep && !coreWrap) |=>
            (core_r == ($past(coreDown) ? $past(core_r) - TIMER_W'(1)
                                        : $past(core_r) + TIMER_W'(1)));
    endproperty
    a_core_dir: assert property (p_core_dir) else $error("core step direction wrong");

    property p_aux_toggle;
        @(posedge clk_sys) disable iff (rst)
            (auxCfg.run && auxCfg.src == dtcr_pkg::DTCR_SRC_TOGGLE && wrap_r) |-> auxStep;
    endproperty
    a_aux_toggle: assert property (p_aux_toggle) else $error("toggle did not clock aux");

    property p_cap_event;
        @(posedge clk_sys) disable iff (rst) capTrig |=> captureEvent;
    endproperty
    a_cap_event: assert property (p_cap_event) else $error("capture event missing");

    c_reload: cover property (@(posedge clk_sys) disable iff (rst) coreWrap && capCfg.reloadEn);
    c_capclr: cover property (@(posedge clk_sys) disable iff (rst) auxClr);
    c_quad: cover property (@(posedge clk_sys) disable iff (rst) capTrig && (rise[5] || fall[6]));
    c_aux_toggle: cover property (@(posedge clk_sys) disable iff (rst)
        auxStep && auxCfg.src == dtcr_pkg::DTCR_SRC_TOGGLE);
    c_underflow: cover property (@(posedge clk_sys) disable iff (rst) coreWrap && coreDown);
endmodule
`default_nettype wire

/* File: test/dtcr_pin_model.sv */
// Model of the external event pins and the neighbour timer inputs.
`timescale 1ns/10ps
`default_nettype none
module dtcr_pin_model (
    input wire logic clk_sys,
    output logic [6:0] pins
);
    // Bits: aux count, core count, aux dir, core dir, capture, quad A, quad B.
    initial pins = 7'h00;
    // Each level holds four cycles, past the synchroniser and the edge spacing.
    task automatic pulse(input int idx);
        repeat (2) begin
            @(posedge clk_sys);
            #2 pins[idx] = ~pins[idx];
            repeat (3) @(posedge clk_sys);
        end
        #2;
    endtask
    task automatic setLevel(input int idx, input logic v);
        @(posedge clk_sys);
        #2 pins[idx] = v;
        repeat (3) @(posedge clk_sys);
        #2;
    endtask
endmodule
`default_nettype wire

/* File: test/dtcr_timer_group_tb.sv */
// Self-checking bench of the dual timer capture/reload group.
`timescale 1ns/10ps
`default_nettype none
module dtcr_timer_group_tb;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    dtcr_pkg::dtcr_tcfg_s auxCfg = '0;
    dtcr_pkg::dtcr_tcfg_s coreCfg = '0;
    dtcr_pkg::dtcr_ccfg_s capCfg = '0;
    logic [6:0] pins;
    logic [15:0] auxTimer, coreTimer, capReg, a0;
    logic latch, outPin, outEn, ccPulse, capEv;
    int n_mismatch = 0;
    int samples_checked = 0;
    int nPulse = 0;
    int nCap = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h000134EE;

    always #12.5 clk_sys = ~clk_sys;

    dtcr_timer_group dtcr_timer_group_inst (.clk_sys(clk_sys), .rst(rst), .auxCfg(auxCfg),
        .coreCfg(coreCfg), .capCfg(capCfg), .auxCountPin(pins[0]), .coreCountPin(pins[1]),
        .auxDirPin(pins[2]), .coreDirPin(pins[3]), .capturePin(pins[4]),
        .quadInputA(pins[5]), .quadInputB(pins[6]), .auxTimer(auxTimer),
        .coreTimer(coreTimer), .captureReloadReg(capReg), .coreToggleLatch(latch),
        .toggleLatchOutPin(outPin), .toggleLatchOutEn(outEn),
        .capcompClockPulse(ccPulse), .captureEvent(capEv));
    dtcr_pin_model dtcr_pin_model_inst (.clk_sys(clk_sys), .pins(pins));

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (ccPulse === 1'b1) nPulse <= nPulse + 1;
        if (capEv === 1'b1) nCap <= nCap + 1;
        if (cycles == 20000) begin
            n_mismatch = n_mismatch + 1;
            report_and_stop();
        end
    end

    function automatic logic [15:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction
    // Expected count change of a prescaled timer over a number of cycles.
    function automatic logic [15:0] expDelta(int cyc, logic [2:0] p, logic down);
        logic [15:0] d;
        d = 16'(cyc / (dtcr_pkg::BASE_DIV << p));
        return down ? -d : d;
    endfunction
    // Expected count change of a pin-clocked timer after n full pulses.
    function automatic logic [15:0] expPin(int n, logic [1:0] ed, logic down);
        logic [15:0] d;
        d = 16'(ed == dtcr_pkg::DTCR_EDGE_BOTH ? 2 * n : n);
        return down ? -d : d;
    endfunction
    task automatic check(string name, logic [47:0] seen, logic [47:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic step(int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        int k;
        int k2;
        int p0;
        int n;
        int c0;
        logic [15:0] r;
        logic [15:0] cb;
        logic [1:0] ed;
        logic [1:0] ce;
        logic both;
        logic an;
        logic dn;
        step(3);
        rst = 1'b0;
        check("reset", {auxTimer, coreTimer, capReg}, 48'h0);
        k = 1 + rnd() % 7;
        auxCfg = '{1'b1, dtcr_pkg::DTCR_SRC_PIN, dtcr_pkg::DTCR_EDGE_RISE, 3'h0, 1'b0, 1'b0};
        repeat (k) dtcr_pin_model_inst.pulse(0);
        step(4);
        check("aux pin count", auxTimer, 16'(k));
        capCfg = '{dtcr_pkg::DTCR_EDGE_RISE, dtcr_pkg::DTCR_EDGE_NONE,
            dtcr_pkg::DTCR_EDGE_NONE, 1'b1, 1'b0, 1'b0};
        dtcr_pin_model_inst.pulse(4);
        step(4);
        check("capture value", capReg, 16'(k));
        check("aux cleared", auxTimer, 16'h0000);
        $display("test capture done");
        k2 = 1 + rnd() % 7;
        capCfg = '{dtcr_pkg::DTCR_EDGE_NONE, dtcr_pkg::DTCR_EDGE_RISE,
            dtcr_pkg::DTCR_EDGE_FALL, 1'b0, 1'b0, 1'b0};
        repeat (k2) dtcr_pin_model_inst.pulse(0);
        dtcr_pin_model_inst.pulse(4);
        step(4);
        check("capture ignored", capReg, 16'(k));
        dtcr_pin_model_inst.pulse(5);
        step(4);
        check("quad A capture", capReg, 16'(k2));
        dtcr_pin_model_inst.pulse(0);
        dtcr_pin_model_inst.pulse(6);
        step(4);
        check("quad B capture", capReg, 16'(k2 + 1));
        $display("test quad capture done");
        p0 = nPulse;
        capCfg.toggleOutEn = 1'b1;
        auxCfg.src = dtcr_pkg::DTCR_SRC_TOGGLE;
        coreCfg = '{1'b1, dtcr_pkg::DTCR_SRC_PIN, dtcr_pkg::DTCR_EDGE_RISE, 3'h0, 1'b1, 1'b1};
        dtcr_pin_model_inst.pulse(1);
        step(4);
        check("core underflow", coreTimer, 16'hFFFF);
        check("toggle latch", latch, 1'b1);
        check("toggle pin", {outPin, outEn}, 2'b10);
        check("aux toggle clock", auxTimer, 16'(k2 + 2));
        check("capcomp pulse", 48'(nPulse - p0), 48'h1);
        dtcr_pin_model_inst.setLevel(3, 1'b1);
        dtcr_pin_model_inst.pulse(1);
        step(4);
        check("core dir pin up", coreTimer, 16'h0000);
        check("toggle latch back", {latch, auxTimer}, {1'b0, 16'(k2 + 3)});
        check("capcomp pulse 2", 48'(nPulse - p0), 48'h2);
        capCfg.reloadEn = 1'b1;
        dtcr_pin_model_inst.setLevel(3, 1'b0);
        dtcr_pin_model_inst.pulse(1);
        step(4);
        check("core reload", coreTimer, 16'(k2 + 1));
        check("reload keeps reg", capReg, 16'(k2 + 1));
        $display("test core wrap done");
        for (int p = 0; p < 3; p++) begin
            auxCfg = '{1'b1, dtcr_pkg::DTCR_SRC_PRESC, dtcr_pkg::DTCR_EDGE_NONE,
                3'(p), 1'(p), 1'b0};
            step(8);
            a0 = auxTimer;
            step(40);
            check("prescaled step", 16'(auxTimer - a0), expDelta(40, 3'(p), 1'(p)));
        end
        $display("test prescaler done");
        // Random rounds: pin edge kind, direction, capture edge, clear and core prescale.
        for (int i = 0; i < 4; i++) begin
            r = rnd();
            ed = 2'(1 + r[1:0] % 3);
            ce = 2'(1 + r[9:8] % 3);
            both = (ce == dtcr_pkg::DTCR_EDGE_BOTH);
            n = 1 + int'(r[6:5]);
            an = r[2] ^ (r[3] & r[4]);
            dn = r[12] ^ (r[13] & r[14]);
            coreCfg = '{1'b1, dtcr_pkg::DTCR_SRC_PRESC, dtcr_pkg::DTCR_EDGE_NONE, 3'(r[11:10]),
                r[12], r[13]};
            auxCfg = '{1'b1, dtcr_pkg::DTCR_SRC_PIN, dtcr_pkg::dtcr_edge_e'(ed), 3'h0,
                r[2], r[3]};
            dtcr_pin_model_inst.setLevel(3, r[14]);
            dtcr_pin_model_inst.setLevel(2, r[4]);
            a0 = auxTimer;
            repeat (n) dtcr_pin_model_inst.pulse(0);
            step(4);
            a0 = 16'(auxTimer - a0);
            check("aux pin edges", a0, expPin(n, ed, an));
            capCfg = '{dtcr_pkg::dtcr_edge_e'(ce), dtcr_pkg::DTCR_EDGE_NONE,
                dtcr_pkg::DTCR_EDGE_NONE, r[7], 1'b0, r[15]};
            a0 = auxTimer;
            c0 = nCap;
            dtcr_pin_model_inst.pulse(4);
            step(4);
            check("random capture", capReg, (both && r[7]) ? 16'h0000 : a0);
            check("random clear", auxTimer, r[7] ? 16'h0000 : a0);
            check("capture events", 48'(nCap - c0), both ? 48'h2 : 48'h1);
            check("toggle pin enable", outEn, !r[15]);
            cb = coreTimer;
            step(48);
            cb = 16'(coreTimer - cb);
            check("core presc", cb, expDelta(48, coreCfg.presc, dn));
            $display("test random round done");
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
